/* File: bench/sls_link_model.sv */
// far-side link engine model issuing transfer and error events
`timescale 1ns/100ps
module sls_link_model (
	input  wire       mclk_i,
	output reg        xfer_start_o,
	output reg        xfer_done_o,
	output reg  [2:0] xfer_stn_o,
	output reg        cycle_end_o,
	output reg        err_stb_o,
	output reg  [2:0] err_stn_o,
	output reg  [7:0] err_code_o
);
	// quiet lines at time zero
	initial
	begin
		{xfer_start_o, xfer_done_o, cycle_end_o, err_stb_o} = 4'h0;
		{xfer_stn_o, err_stn_o, err_code_o} = 14'h0000;
	end
	// one-cycle event; k is {error, cycle end, done, start}
	task ev(input [3:0] k, input [2:0] s, input [7:0] c);
	begin
		@(posedge mclk_i);
		{err_stb_o, cycle_end_o, xfer_done_o, xfer_start_o} <= k;
		xfer_stn_o <= s;
		err_stn_o <= s;
		err_code_o <= c;
		@(posedge mclk_i);
		{err_stb_o, cycle_end_o, xfer_done_o, xfer_start_o} <= 4'h0;
		// released lines show the inverse, never a stale copy
		{xfer_stn_o, err_stn_o, err_code_o} <= ~{s, s, c};
	end
	endtask
endmodule // sls_link_model

/* File: bench/sls_top_props.sv */
// concurrent checks on the link supervisor ports
`timescale 1ns/100ps
module sls_chk #(
	parameter TICK_CYC = 10 // clock cycles per tick
) (
	input wire        mclk_i,
	input wire        rstn_i,
	input wire        err_stb_i,
	input wire [2:0]  err_stn_i,
	input wire        retry_o,
	input wire [7:0]  seq_flag_o,
	input wire        is_master_o,
	input wire [3:0]  word_cnt_o,
	input wire [6:0]  bit_cnt_o,
	input wire [6:0]  word_base_o,
	input wire [10:0] bit_base_o
);
	// one clock domain, reset quiets every check
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	word_count_a: assert property (
		word_cnt_o == 4'h4 || word_cnt_o == 4'h8) else $error("word count off");
	area_pair_a: assert property (
		(word_cnt_o == 4'h8) == (bit_cnt_o == 7'h40)) else $error("bit count off");
	bit_base_a: assert property (
		bit_base_o == 11'h3E8 + 11'h040 * ({4'h0, word_base_o} / 11'h00A))
		else $error("bit base off");
	word_base_a: assert property (
		word_base_o % 7'h0A == 7'h00 && word_base_o <= 7'h46)
		else $error("word base off");
	master_role_a: assert property (
		is_master_o == (word_base_o == 7'h00)) else $error("master flag off");
	retry_pulse_a: assert property (
		retry_o |=> !retry_o) else $error("retry held too long");
	retry_role_a: assert property (
		retry_o |-> is_master_o) else $error("retry from a slave");
	peer_err_a: assert property (
		err_stb_i && {4'h0, err_stn_i} * 7'h0A != word_base_o
		|-> ##2 seq_flag_o[$past(err_stn_i, 2)]) else $error("flag missing");
	own_err_a: assert property (
		err_stb_i && {4'h0, err_stn_i} * 7'h0A == word_base_o
		&& !seq_flag_o[err_stn_i] |-> ##2 !seq_flag_o[$past(err_stn_i, 2)])
		else $error("own flag set");
endmodule // sls_chk
bind sls_top sls_chk #(.TICK_CYC(TICK_CYC)) u_chk (
	.mclk_i      (mclk_i),
	.rstn_i      (rstn_i),
	.err_stb_i   (err_stb_i),
	.err_stn_i   (err_stn_i),
	.retry_o     (retry_o),
	.seq_flag_o  (seq_flag_o),
	.is_master_o (is_master_o),
	.word_cnt_o  (word_cnt_o),
	.bit_cnt_o   (bit_cnt_o),
	.word_base_o (word_base_o),
	.bit_base_o  (bit_base_o)
);

/* File: bench/station_link_supervisor_tb.sv */
// self-checking bench for the station link supervisor
`timescale 1ns/100ps
`include "sls_regs.vh"
module station_link_supervisor_tb;
	localparam TK = 10; // short tick keeps timeouts brief
	reg         mclk_i, rstn_i, wr_i, rd_i;
	reg  [4:0]  addr_i;
	reg  [15:0] wdata_i, n_retry;
	wire        xfer_start_i, xfer_done_i, cycle_end_i, err_stb_i;
	wire        retry_o, is_master_o;
	wire [2:0]  xfer_stn_i, err_stn_i;
	wire [7:0]  err_code_i, abnormal_o, seq_flag_o;
	wire [15:0] rdata_o;
	wire [3:0]  word_cnt_o;
	wire [6:0]  bit_cnt_o, word_base_o;
	wire [10:0] bit_base_o;
	integer     checks, n_mismatch, cyc, i, n;
	sls_top #(.TICK_CYC(TK)) uut (
		.mclk_i       (mclk_i),
		.rstn_i       (rstn_i),
		.addr_i       (addr_i),
		.wdata_i      (wdata_i),
		.wr_i         (wr_i),
		.rd_i         (rd_i),
		.rdata_o      (rdata_o),
		.xfer_start_i (xfer_start_i),
		.xfer_done_i  (xfer_done_i),
		.xfer_stn_i   (xfer_stn_i),
		.cycle_end_i  (cycle_end_i),
		.err_stb_i    (err_stb_i),
		.err_stn_i    (err_stn_i),
		.err_code_i   (err_code_i),
		.retry_o      (retry_o),
		.abnormal_o   (abnormal_o),
		.seq_flag_o   (seq_flag_o),
		.is_master_o  (is_master_o),
		.word_cnt_o   (word_cnt_o),
		.bit_cnt_o    (bit_cnt_o),
		.word_base_o  (word_base_o),
		.bit_base_o   (bit_base_o)
	);
	sls_link_model lk (.mclk_i(mclk_i), .xfer_start_o(xfer_start_i),
		.xfer_done_o(xfer_done_i), .xfer_stn_o(xfer_stn_i),
		.cycle_end_o(cycle_end_i), .err_stb_o(err_stb_i),
		.err_stn_o(err_stn_i), .err_code_o(err_code_i));
	// clock at 100 MHz
	initial
	begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// counts retry pulses and cuts a hang short
	always @(posedge mclk_i)
	begin
		cyc = cyc + 1;
		if (retry_o === 1'b1)
			n_retry = n_retry + 16'h0001;
		if (cyc == 20000)
		begin
			n_mismatch = n_mismatch + 1;
			close_out;
		end
	end
	task chk(input [15:0] got, input [15:0] exp);
	begin
		checks = checks + 1;
		if (got !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask
	task wr(input [4:0] a, input [15:0] d);
	begin
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	end
	endtask
	// read data stands only in the cycle after the strobe
	task rd(input [4:0] a, input [15:0] e);
	begin
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	end
	endtask
	// lets registered outputs follow a register change
	task step;
	begin
		@(posedge mclk_i);
		#1;
	end
	endtask
	task close_out;
	begin
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		{rstn_i, wr_i, rd_i, addr_i, wdata_i, n_retry} = 40'h0;
		checks = 0;
		n_mismatch = 0;
		cyc = 0;
		repeat (4) @(posedge mclk_i);
		rstn_i <= 1'b1;
		// cycle ends 40 then 20 clocks apart: 4 then 2 ticks
		lk.ev(4'h4, 3'h0, 8'h00);
		repeat (38) @(posedge mclk_i);
		lk.ev(4'h4, 3'h0, 8'h00);
		repeat (18) @(posedge mclk_i);
		lk.ev(4'h4, 3'h0, 8'h00);
		rd(`SLS_A_CUR_CYC, 16'h0002);
		rd(`SLS_A_PEAK_CYC, 16'h0004);
		$display("cycle statistics test done");
		// reset values, limits, read-only and unmapped places
		rd(`SLS_A_STATION, 16'h0000);
		rd(`SLS_A_RETRY, 16'h0003);
		rd(`SLS_A_WATCH, 16'h0005);
		for (i = 0; i < 8; i = i + 1)
			rd(`SLS_A_CNT_BASE + i[4:0], 16'h0000);
		rd(5'h18, 16'h0000);
		wr(`SLS_A_RETRY, 16'h000A);
		wr(`SLS_A_RETRY, 16'h000B);
		rd(`SLS_A_RETRY, 16'h000A);
		wr(`SLS_A_WATCH, 16'h0004);
		rd(`SLS_A_WATCH, 16'h0005);
		wr(`SLS_A_WATCH, 16'h00FF);
		rd(`SLS_A_WATCH, 16'h00FF);
		wr(`SLS_A_PEAK_CYC, 16'h1234);
		rd(`SLS_A_PEAK_CYC, 16'h0004);
		$display("register test done");
		// every pattern, a refused pattern, every station number
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(`SLS_A_PATTERN, i[15:0]);
			step;
			chk({9'h0, bit_cnt_o}, (i == 3) ? 16'h0040 : 16'h0020 * i[15:0]);
			chk({12'h0, word_cnt_o}, (i > 1) ? 16'h0008 : 16'h0004);
		end
		wr(`SLS_A_PATTERN, 16'h0000);
		for (i = 7; i >= 0; i = i - 1)
		begin
			wr(`SLS_A_STATION, i[15:0]);
			step;
			chk({5'h0, bit_base_o}, 16'h03E8 + 16'h0040 * i[15:0]);
			chk({9'h0, word_base_o}, 16'h000A * i[15:0]);
			chk({15'h0, is_master_o}, {15'h0, i == 0});
		end
		$display("area test done");
		// error events for every station, own station ignored
		for (i = 0; i < 8; i = i + 1)
		begin
			lk.ev(4'h8, i[2:0], 8'h01 + {6'h0, i[1:0]});
			step;
			chk({15'h0, seq_flag_o[i]}, {15'h0, i != 0});
			rd(`SLS_A_CNT_BASE + i[4:0], {15'h0, i != 0});
			rd(`SLS_A_CODE_BASE + i[4:0], (i == 0) ? 16'h0000 :
				16'h0001 + {14'h0, i[1:0]});
		end
		lk.ev(4'h8, 3'h7, 8'h04);
		rd(`SLS_A_CNT_BASE + 5'h07, 16'h0002);
		wr(`SLS_A_FLAGS, 16'h00FF);
		step;
		chk({8'h0, seq_flag_o}, 16'h0000);
		$display("error counter test done");
		// prompt peer, then a silent peer with one retry
		wr(`SLS_A_RETRY, 16'h0001);
		wr(`SLS_A_WATCH, 16'h0005);
		lk.ev(4'h1, 3'h4, 8'h00);
		lk.ev(4'h2, 3'h4, 8'h00);
		lk.ev(4'h1, 3'h2, 8'h00);
		for (n = 0; n < 100 && n_retry == 16'h0000; n = n + 1)
			@(posedge mclk_i);
		chk(n_retry, 16'h0001);
		lk.ev(4'h1, 3'h2, 8'h00);
		for (n = 0; n < 100 && seq_flag_o[2] !== 1'b1; n = n + 1)
			@(posedge mclk_i);
		step;
		chk({8'h0, seq_flag_o}, 16'h0004);
		chk({8'h0, abnormal_o}, 16'h0004);
		chk(n_retry, 16'h0001);
		rd(`SLS_A_CNT_BASE + 5'h02, 16'h0002);
		rd(`SLS_A_CODE_BASE + 5'h02, 16'h0001);
		$display("watchdog test done");
		// slave role: cycle ends ignored, no retry, master blamed
		wr(`SLS_A_ABNORMAL, 16'h00FF);
		wr(`SLS_A_STATION, 16'h0003);
		step;
		chk({8'h0, abnormal_o}, 16'h0000);
		lk.ev(4'h4, 3'h0, 8'h00);
		rd(`SLS_A_CUR_CYC, 16'h0002);
		lk.ev(4'h1, 3'h0, 8'h00);
		for (n = 0; n < 100 && seq_flag_o[0] !== 1'b1; n = n + 1)
			@(posedge mclk_i);
		step;
		chk({8'h0, seq_flag_o}, 16'h0005);
		chk({8'h0, abnormal_o}, 16'h0001);
		chk(n_retry, 16'h0001);
		rd(`SLS_A_CNT_BASE, 16'h0001);
		rd(`SLS_A_CODE_BASE, 16'h0011);
		$display("slave watchdog test done");
		close_out;
	end
endmodule // station_link_supervisor_tb

/* File: design/sls_regs.vh */
// register map, field codes and timing constants of the link supervisor
`ifndef SLS_REGS_VH
`define SLS_REGS_VH
// register word offsets
`define SLS_A_STATION   5'h00
`define SLS_A_PATTERN   5'h01
`define SLS_A_RETRY     5'h02
`define SLS_A_WATCH     5'h03
`define SLS_A_CUR_CYC   5'h04
`define SLS_A_PEAK_CYC  5'h05
`define SLS_A_FLAGS     5'h06
`define SLS_A_ABNORMAL  5'h07
`define SLS_A_CNT_BASE  5'h08
`define SLS_A_CODE_BASE 5'h10
// reset values
`define SLS_RST_STATION 3'h0
`define SLS_RST_PATTERN 2'h0
`define SLS_RST_RETRY   4'h3
`define SLS_RST_WATCH   8'h05
// legal ranges
`define SLS_PATTERN_MAX 2'h2
`define SLS_RETRY_MAX   4'hA
`define SLS_WATCH_MIN   8'h05
// area sizes per pattern
`define SLS_WORDS_P01   4'h4
`define SLS_WORDS_P2    4'h8
`define SLS_BITS_P0     7'h00
`define SLS_BITS_P1     7'h20
`define SLS_BITS_P2     7'h40
// area bases
`define SLS_WORD_STEP   4'hA
`define SLS_BIT_BASE    11'h3E8
`define SLS_BIT_STEP    11'h040
// error codes
`define SLS_EC_TIMEOUT  8'h01
`define SLS_EC_MST_TMO  8'h11
// time base
`define SLS_TICK_MS     10
`define SLS_CLK_MHZ     100
`define SLS_TICK_CYC    (`SLS_TICK_MS * 1000 * `SLS_CLK_MHZ)
`endif

/* File: design/sls_top.v */
// station link supervisor: settings, watchdog, retries and statistics
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
`include "sls_regs.vh"
module sls_top #(
	parameter TICK_CYC = `SLS_TICK_CYC // clock cycles per 10 ms tick
) (
	input  wire        mclk_i,        // system clock
	input  wire        rstn_i,        // async reset, active low
	input  wire [4:0]  addr_i,        // register word address
	input  wire [15:0] wdata_i,       // write data
	input  wire        wr_i,          // write strobe
	input  wire        rd_i,          // read strobe
	output reg  [15:0] rdata_o,       // read data, cycle after rd_i
	input  wire        xfer_start_i,  // a transfer with a station begins
	input  wire        xfer_done_i,   // that transfer completed well
	input  wire [2:0]  xfer_stn_i,    // peer station of the transfer
	input  wire        cycle_end_i,   // network cycle finished
	input  wire        err_stb_i,     // link engine saw a sequence error
	input  wire [2:0]  err_stn_i,     // station in error
	input  wire [7:0]  err_code_i,    // cause code of that error
	output reg         retry_o,       // pulse: resend to the peer
	output reg  [7:0]  abnormal_o,    // per-station watch timeout flag
	output reg  [7:0]  seq_flag_o,    // per-station sequence error flag
	output reg         is_master_o,   // own station is the master
	output reg  [3:0]  word_cnt_o,    // link words per station
	output reg  [6:0]  bit_cnt_o,     // link bits per station
	output reg  [6:0]  word_base_o,   // own word area start
	output reg  [10:0] bit_base_o     // own bit area start
);

	// last divider count, cut to the divider width on purpose
	localparam integer TICK_LAST_I = TICK_CYC - 1;
	localparam [19:0]  TICK_LAST   = TICK_LAST_I[19:0];

	reg  [2:0]  station_q;   // own station number
	reg  [1:0]  pattern_q;   // refresh pattern
	reg  [3:0]  retry_q;     // retry limit
	reg  [7:0]  watch_q;     // watch time in ticks
	reg  [15:0] cur_q;       // last cycle length
	reg  [15:0] peak_q;      // longest cycle length
	reg  [15:0] run_q;       // ticks in running cycle
	reg  [19:0] div_q;       // tick divider
	reg         tick_q;      // one-cycle 10 ms tick
	reg         busy_q;      // watchdog armed
	reg  [7:0]  wd_q;        // ticks elapsed in transfer
	reg  [2:0]  peer_q;      // station of running transfer
	reg  [3:0]  tries_q;     // retries spent on this peer
	reg         tmo_q;       // internal timeout error event
	reg  [2:0]  tmo_stn_q;   // station of that event
	reg  [7:0]  tmo_code_q;  // code of that event
	wire [15:0] cnt_w [0:7]; // error counters
	wire [7:0]  code_w [0:7]; // latest error codes
	wire [7:0]  flag_w;      // sequence flags
	wire [7:0]  abn_w;       // abnormal flags
	wire        wr_flags;    // write-one-to-clear of flags
	wire        wr_abn;      // write-one-to-clear of abnormal
	wire        wd_fire;     // watch time exceeded
	wire [2:0]  tmo_peer;    // station blamed for timeout

	assign wr_flags = wr_i && (addr_i == `SLS_A_FLAGS);
	assign wr_abn   = wr_i && (addr_i == `SLS_A_ABNORMAL);
	// exceeded when a tick arrives with the full time already spent
	assign wd_fire  = busy_q && tick_q && (wd_q == watch_q);
	// master blames the slave, a slave blames the master
	assign tmo_peer = (station_q == 3'h0) ? peer_q : 3'h0;

	// settings written by software; pattern, retry limit and watch time range-checked
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			station_q <= `SLS_RST_STATION;
			pattern_q <= `SLS_RST_PATTERN;
			retry_q   <= `SLS_RST_RETRY;
			watch_q   <= `SLS_RST_WATCH;
		end
		else if (wr_i)
		begin
			case (addr_i)
			`SLS_A_STATION:
				station_q <= wdata_i[2:0];
			`SLS_A_PATTERN:
				// out-of-range pattern keeps the old one
				if (wdata_i <= {14'h0, `SLS_PATTERN_MAX})
					pattern_q <= wdata_i[1:0];
			`SLS_A_RETRY:
				if (wdata_i <= {12'h0, `SLS_RETRY_MAX})
					retry_q <= wdata_i[3:0];
			`SLS_A_WATCH:
				if (wdata_i >= {8'h0, `SLS_WATCH_MIN} &&
				    wdata_i[15:8] == 8'h00)
					watch_q <= wdata_i[7:0];
			default:
				; // statistics are not writable
			endcase
		end
	end

	// 10 ms time base
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			div_q  <= 20'h00000;
			tick_q <= 1'b0;
		end
		else if (div_q == TICK_LAST)
		begin
			div_q  <= 20'h00000;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q  <= div_q + 20'h00001;
			tick_q <= 1'b0;
		end
	end

	// cycle time statistics, kept by the master only
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			run_q  <= 16'h0000;
			cur_q  <= 16'h0000;
			peak_q <= 16'h0000;
		end
		else if (cycle_end_i && station_q == 3'h0)
		begin
			cur_q <= run_q;
			if (run_q > peak_q)
				peak_q <= run_q;
			// a tick in the closing cycle starts the new one at 1
			run_q <= tick_q ? 16'h0001 : 16'h0000;
		end
		else if (tick_q && run_q != 16'hFFFF)
			run_q <= run_q + 16'h0001; // saturates
	end

	// transfer watchdog and retry control
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			busy_q     <= 1'b0;
			wd_q       <= 8'h00;
			peer_q     <= 3'h0;
			tries_q    <= 4'h0;
			retry_o    <= 1'b0;
			tmo_q      <= 1'b0;
			tmo_stn_q  <= 3'h0;
			tmo_code_q <= 8'h00;
		end
		else
		begin
			retry_o <= 1'b0;
			tmo_q   <= 1'b0;
			if (xfer_done_i)
			begin
				// good answer ends the transfer and its retries
				busy_q  <= 1'b0;
				tries_q <= 4'h0;
			end
			else if (xfer_start_i)
			begin
				busy_q <= 1'b1;
				wd_q   <= 8'h00;
				if (xfer_stn_i != peer_q)
					tries_q <= 4'h0;
				peer_q <= xfer_stn_i;
			end
			else if (wd_fire)
			begin
				busy_q <= 1'b0;
				if (station_q == 3'h0 && tries_q < retry_q)
				begin
					tries_q <= tries_q + 4'h1;
					retry_o <= 1'b1;
				end
				else
				begin
					// no retry left, or a slave: sequence error on the station in tmo_peer
					tries_q    <= 4'h0;
					tmo_q      <= 1'b1;
					tmo_stn_q  <= tmo_peer;
					tmo_code_q <= (station_q == 3'h0) ?
						`SLS_EC_TIMEOUT : `SLS_EC_MST_TMO;
				end
			end
			else if (busy_q && tick_q)
				wd_q <= wd_q + 8'h01;
		end
	end

	// per-station error bookkeeping
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1)
		begin : g_stn
			reg  [15:0] cnt_q;  // sequence error count
			reg  [7:0]  code_q; // latest cause
			reg         flag_q; // sequence error flag
			reg         abn_q;  // abnormal flag
			wire        own;    // this entry is the own station
			wire        hit_i;  // internal event for this station
			wire        hit_e;  // external event for this station
			wire        ev;     // any counted event
			wire        tmo;    // watchdog blames this station

			assign own   = (station_q == i);
			assign hit_i = tmo_q && (tmo_stn_q == i);
			assign hit_e = err_stb_i && (err_stn_i == i);
			assign ev    = (hit_i || hit_e) && !own;
			assign tmo   = wd_fire && (tmo_peer == i) && !own;

			// counter, code and flag of one station
			always @(posedge mclk_i or negedge rstn_i)
			begin
				if (!rstn_i)
				begin
					cnt_q  <= 16'h0000;
					code_q <= 8'h00;
					flag_q <= 1'b0;
					abn_q  <= 1'b0;
				end
				else
				begin
					if (ev && cnt_q != 16'hFFFF)
						cnt_q <= cnt_q + 16'h0001;
					if (ev)
						code_q <= hit_i ? tmo_code_q
							: err_code_i;
					// a new error wins over the clear
					if (ev)
						flag_q <= 1'b1;
					else if (wr_flags && wdata_i[i])
						flag_q <= 1'b0;
					if (tmo)
						abn_q <= 1'b1;
					else if (wr_abn && wdata_i[i])
						abn_q <= 1'b0;
				end
			end

			assign cnt_w[i]  = cnt_q;
			assign code_w[i] = code_q;
			assign flag_w[i] = flag_q;
			assign abn_w[i]  = abn_q;
		end
	endgenerate

	// registered status and area outputs
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			abnormal_o  <= 8'h00;
			seq_flag_o  <= 8'h00;
			is_master_o <= 1'b1;
			word_cnt_o  <= `SLS_WORDS_P01;
			bit_cnt_o   <= `SLS_BITS_P0;
			word_base_o <= 7'h00;
			bit_base_o  <= `SLS_BIT_BASE;
		end
		else
		begin
			abnormal_o  <= abn_w;
			seq_flag_o  <= flag_w;
			is_master_o <= (station_q == 3'h0);
			case (pattern_q)
			2'h0:
			begin
				word_cnt_o <= `SLS_WORDS_P01;
				bit_cnt_o  <= `SLS_BITS_P0;
			end
			2'h1:
			begin
				word_cnt_o <= `SLS_WORDS_P01;
				bit_cnt_o  <= `SLS_BITS_P1;
			end
			default:
			begin
				word_cnt_o <= `SLS_WORDS_P2;
				bit_cnt_o  <= `SLS_BITS_P2;
			end
			endcase
			// bases depend on the station number only
			word_base_o <= {4'h0, station_q} * {3'h0, `SLS_WORD_STEP};
			bit_base_o  <= `SLS_BIT_BASE +
				{8'h00, station_q} * `SLS_BIT_STEP;
		end
	end

	// read port, data one cycle after the strobe
	always @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rdata_o <= 16'h0000;
		else if (rd_i)
		begin
			if (addr_i[4:3] == 2'b01)
				rdata_o <= cnt_w[addr_i[2:0]];
			else if (addr_i[4:3] == 2'b10)
				rdata_o <= {8'h00, code_w[addr_i[2:0]]};
			else
			begin
				case (addr_i)
				`SLS_A_STATION:  rdata_o <= {13'h0, station_q};
				`SLS_A_PATTERN:  rdata_o <= {14'h0, pattern_q};
				`SLS_A_RETRY:    rdata_o <= {12'h0, retry_q};
				`SLS_A_WATCH:    rdata_o <= {8'h00, watch_q};
				`SLS_A_CUR_CYC:  rdata_o <= cur_q;
				`SLS_A_PEAK_CYC: rdata_o <= peak_q;
				`SLS_A_FLAGS:    rdata_o <= {8'h00, flag_w};
				`SLS_A_ABNORMAL: rdata_o <= {8'h00, abn_w};
				default:         rdata_o <= 16'h0000; // unmapped
				endcase
			end
		end
		else
			rdata_o <= 16'h0000;
	end

endmodule // sls_top
